// File: rtl/gdc_pkg.sv
// Shared constants for the bus command decoder: command codes, address
// groups, buffer sizes and the state encodings of both handshakes.
// Assumes one 100 MHz clock and a low-true bus sampled synchronously.
package gdc_pkg;

    // ========================================================================
    // Data widths and buffering
    // ========================================================================
    localparam int GDC_DATA_W = 8;
    localparam int GDC_FIFO_DEPTH = 4;
    localparam int GDC_ADDR_W = 5;

    // ========================================================================
    // Multiline command codes, seven bits wide
    // ========================================================================
    localparam logic [6:0] GDC_CMD_GTL = 7'h01;
    localparam logic [6:0] GDC_CMD_SDC = 7'h04;
    localparam logic [6:0] GDC_CMD_GET = 7'h08;
    localparam logic [6:0] GDC_CMD_LLO = 7'h11;
    localparam logic [6:0] GDC_CMD_DCL = 7'h14;
    localparam logic [6:0] GDC_CMD_SPE = 7'h18;
    localparam logic [6:0] GDC_CMD_SPD = 7'h19;
    localparam logic [6:0] GDC_CMD_UNL = 7'h3f;
    localparam logic [6:0] GDC_CMD_UNT = 7'h5f;

    // ========================================================================
    // Address groups held in bits 6 and 5 of a command byte
    // ========================================================================
    localparam logic [1:0] GDC_GRP_LISTEN = 2'h1;
    localparam logic [1:0] GDC_GRP_TALK = 2'h2;
    localparam logic [1:0] GDC_GRP_SECOND = 2'h3;

    // Position of the request-service bit in the serial poll status byte.
    localparam int GDC_STB_RQS_BIT = 6;

    // ========================================================================
    // State machines
    // ========================================================================
    typedef enum logic [3:0] {
        GDC_ACC_IDLE = 4'h1,
        GDC_ACC_READY = 4'h2,
        GDC_ACC_TAKE = 4'h4,
        GDC_ACC_DONE = 4'h8
    } gdc_acc_state_t;

    typedef enum logic [3:0] {
        GDC_SRC_IDLE = 4'h1,
        GDC_SRC_SETUP = 4'h2,
        GDC_SRC_VALID = 4'h4,
        GDC_SRC_END = 4'h8
    } gdc_src_state_t;

endpackage : gdc_pkg

// File: rtl/gdc_top.sv
// Device side of the instrument bus: acceptor and source handshakes,
// multiline command decode, listen/talk addressing and remote/local state.
// Assumes every bus pin is sampled as synchronous to clk_in and that the
// open-drain wiring is resolved outside from the output enables.
//
// Notes on behaviour
// - Addressed commands take effect only while the device is a listener.
// - Selective clear 04 while listening pulses the device clear output.
// - Go-to-local 01 while listening drops remote mode.
// - Group execute trigger 08 while listening pulses the trigger output.
// - Own address with bit 5 set and bit 6 clear makes the device a listener.
// - Own address with bit 6 set and bit 5 clear makes the device a talker.
// - Secondary bytes 60 to 7F are ignored.
// - Unlisten 3F returns the listener to idle.
// - Untalk 5F returns the talker to idle.
// - Universal commands 11, 14, 18, 19 are decoded.
// - Bytes with attention false go to the listener as device data.
// - Talker with serial poll; own listen address ends talking.
// - Data bytes are sourced only while addressed to talk.
// - Data accepted only when listening; own talk address ends listening.
// - The device can pull the service request line.
// - No parallel poll, no controller, never drives attention, clear, remote.
// - Full source handshake for sending bytes as talker.
// - Full acceptor handshake, each byte held until taken.
// - Remote/local state under bus control.
// - Device clear commands supported; no extended addressing.
// - Commands decoded only while attention is true.
// - Interface clear idles both talker and listener.
// - With remote enable true, own listen address enters remote.
// - Source waits for ready and not-accepted before asserting data valid.
`timescale 1ns/1ps

// ============================================================================
// Receive buffer
// ============================================================================
module gdc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    logic [PW:0] count_next;
    logic push;
    logic pop;

    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_reg[rd_ptr_reg];

    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            in_ready_out <= 1'b1;
            out_valid_out <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
            // Flags come from flops so the source sees an honest full.
            in_ready_out <= (count_next != FULL_CNT);
            out_valid_out <= (count_next != '0);
        end
    end
endmodule : gdc_fifo

// ============================================================================
// Command decoder and handshakes
// ============================================================================
module gdc_top
    import gdc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [GDC_ADDR_W-1:0] prim_addr_in,
    input wire logic [7:0] dio_n_in,
    output logic [7:0] dio_out,
    output logic [7:0] dio_oe_out,
    input wire logic atn_n_in,
    input wire logic ifc_n_in,
    input wire logic ren_n_in,
    input wire logic dav_n_in,
    output logic dav_out,
    output logic dav_oe_out,
    input wire logic nrfd_n_in,
    output logic nrfd_out,
    output logic nrfd_oe_out,
    input wire logic ndac_n_in,
    output logic ndac_out,
    output logic ndac_oe_out,
    input wire logic eoi_n_in,
    output logic eoi_out,
    output logic eoi_oe_out,
    output logic srq_out,
    output logic srq_oe_out,
    input wire logic srq_req_in,
    input wire logic [7:0] status_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_last_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    output logic listen_out,
    output logic talk_out,
    output logic remote_out,
    output logic lockout_out,
    output logic spoll_out,
    output logic clear_out,
    output logic trigger_out
);
    gdc_acc_state_t acc_reg;
    gdc_acc_state_t acc_next;
    gdc_src_state_t src_reg;
    gdc_src_state_t src_next;
    logic [7:0] byte_reg;
    logic byte_atn_reg;
    logic [7:0] out_byte_reg;
    logic out_last_reg;
    logic rqs_reg;
    logic srq_req_reg;
    logic fifo_ready;
    logic atn;
    logic ren;
    logic ifc;
    logic cmd_stb;
    logic [6:0] cmd;
    logic my_addr;
    logic src_active;
    logic src_take;
    logic data_push;

    // Bus lines are low true; an open-drain pin only ever pulls low.
    assign atn = !atn_n_in;
    assign ren = !ren_n_in;
    assign ifc = !ifc_n_in;
    assign dio_out = 8'h00;
    assign dav_out = 1'b0;
    assign nrfd_out = 1'b0;
    assign ndac_out = 1'b0;
    assign eoi_out = 1'b0;
    assign srq_out = 1'b0;

    // ========================================================================
    // Command decode
    // ========================================================================
    assign cmd = byte_reg[6:0];
    assign my_addr = (cmd[4:0] == prim_addr_in);
    assign cmd_stb = (acc_reg == GDC_ACC_TAKE) && byte_atn_reg;
    assign data_push = (acc_reg == GDC_ACC_TAKE) && !byte_atn_reg
        && listen_out;

    // ========================================================================
    // Acceptor handshake
    // ========================================================================
    // Every device joins the handshake under attention; otherwise only a
    // listener does, so an unaddressed device never holds up the bus.
    always_comb begin
        acc_next = acc_reg;
        case (acc_reg)
            GDC_ACC_IDLE: begin
                if (atn || listen_out) begin
                    acc_next = GDC_ACC_READY;
                end
            end
            GDC_ACC_READY: begin
                if (!atn && !listen_out) begin
                    acc_next = GDC_ACC_IDLE;
                end else if (!dav_n_in && !nrfd_oe_out) begin
                    acc_next = GDC_ACC_TAKE;
                end
            end
            GDC_ACC_TAKE: begin
                acc_next = GDC_ACC_DONE;
            end
            GDC_ACC_DONE: begin
                if (dav_n_in) begin
                    acc_next = GDC_ACC_READY;
                end
            end
            default: begin
                acc_next = GDC_ACC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_reg <= GDC_ACC_IDLE;
            nrfd_oe_out <= 1'b0;
            ndac_oe_out <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            // Ready is withheld while attention is false and the buffer is full, so a slow reader
            // stalls the talker instead of losing bytes.
            nrfd_oe_out <= (acc_next != GDC_ACC_IDLE) && !((acc_next ==
                GDC_ACC_READY) && (atn || fifo_ready));
            ndac_oe_out <= (acc_next == GDC_ACC_READY)
                || (acc_next == GDC_ACC_TAKE);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            byte_reg <= 8'h00;
            byte_atn_reg <= 1'b0;
        end else if (acc_next == GDC_ACC_TAKE && acc_reg == GDC_ACC_READY) begin
            byte_reg <= ~dio_n_in;
            byte_atn_reg <= atn;
        end
    end

    gdc_fifo #(
        .WIDTH(GDC_DATA_W),
        .DEPTH(GDC_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .in_data_in(byte_reg),
        .in_valid_in(data_push),
        .in_ready_out(fifo_ready),
        .out_data_out(rx_data_out),
        .out_valid_out(rx_valid_out),
        .out_ready_in(rx_ready_in)
    );

    // ========================================================================
    // Listen and talk addressing
    // ========================================================================
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            listen_out <= 1'b0;
            talk_out <= 1'b0;
        end else if (ifc) begin
            listen_out <= 1'b0;
            talk_out <= 1'b0;
        end else if (cmd_stb) begin
            if (cmd == GDC_CMD_UNL) begin
                listen_out <= 1'b0;
            end else if (cmd == GDC_CMD_UNT) begin
                talk_out <= 1'b0;
            end else if (cmd[6:5] == GDC_GRP_LISTEN && my_addr) begin
                listen_out <= 1'b1;
                talk_out <= 1'b0;
            end else if (cmd[6:5] == GDC_GRP_TALK) begin
                // Another device's talk address also ends our talking.
                talk_out <= my_addr;
                if (my_addr) begin
                    listen_out <= 1'b0;
                end
            end
        end
    end

    // ========================================================================
    // Remote, lockout, serial poll, clear and trigger
    // ========================================================================
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            remote_out <= 1'b0;
            lockout_out <= 1'b0;
        end else if (!ren) begin
            remote_out <= 1'b0;
            lockout_out <= 1'b0;
        end else if (cmd_stb) begin
            if (cmd == GDC_CMD_LLO) begin
                lockout_out <= 1'b1;
            end else if (cmd == GDC_CMD_GTL && listen_out) begin
                remote_out <= 1'b0;
            end else if (cmd[6:5] == GDC_GRP_LISTEN && my_addr
                && cmd != GDC_CMD_UNL) begin
                remote_out <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            spoll_out <= 1'b0;
            clear_out <= 1'b0;
            trigger_out <= 1'b0;
        end else begin
            clear_out <= cmd_stb && (cmd == GDC_CMD_DCL
                || (cmd == GDC_CMD_SDC && listen_out));
            trigger_out <= cmd_stb && cmd == GDC_CMD_GET && listen_out;
            if (ifc) begin
                spoll_out <= 1'b0;
            end else if (cmd_stb && cmd == GDC_CMD_SPE) begin
                spoll_out <= 1'b1;
            end else if (cmd_stb && cmd == GDC_CMD_SPD) begin
                spoll_out <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Service request
    // ========================================================================
    // One request per rise; a poll withdraws it.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rqs_reg <= 1'b0;
            srq_oe_out <= 1'b0;
            srq_req_reg <= 1'b0;
        end else begin
            srq_req_reg <= srq_req_in;
            if (srq_req_in && !srq_req_reg) begin
                rqs_reg <= 1'b1;
            end else if (src_take && spoll_out) begin
                rqs_reg <= 1'b0;
            end
            if (!srq_req_in) begin
                srq_oe_out <= 1'b0;
            end else if (!srq_req_reg) begin
                srq_oe_out <= 1'b1;
            end else if (src_take && spoll_out) begin
                srq_oe_out <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Source handshake
    // ========================================================================
    assign src_active = talk_out && !atn;
    assign src_take = tx_ready_out && (spoll_out || tx_valid_in);

    always_comb begin
        src_next = src_reg;
        case (src_reg)
            GDC_SRC_IDLE: begin
                if (src_take && src_active) begin
                    src_next = GDC_SRC_SETUP;
                end
            end
            GDC_SRC_SETUP: begin
                if (!src_active) begin
                    src_next = GDC_SRC_IDLE;
                end else if (nrfd_n_in && !ndac_n_in) begin
                    src_next = GDC_SRC_VALID;
                end
            end
            GDC_SRC_VALID: begin
                if (!src_active) begin
                    src_next = GDC_SRC_IDLE;
                end else if (ndac_n_in) begin
                    src_next = GDC_SRC_END;
                end
            end
            GDC_SRC_END: begin
                src_next = GDC_SRC_IDLE;
            end
            default: begin
                src_next = GDC_SRC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            src_reg <= GDC_SRC_IDLE;
            out_byte_reg <= 8'h00;
            out_last_reg <= 1'b0;
            tx_ready_out <= 1'b0;
            dav_oe_out <= 1'b0;
            dio_oe_out <= 8'h00;
            eoi_oe_out <= 1'b0;
        end else begin
            src_reg <= src_next;
            if (src_take && src_active && src_reg == GDC_SRC_IDLE) begin
                if (spoll_out) begin
                    out_byte_reg <= status_in;
                    out_byte_reg[GDC_STB_RQS_BIT] <= rqs_reg;
                    out_last_reg <= 1'b0;
                end else begin
                    out_byte_reg <= tx_data_in;
                    out_last_reg <= tx_last_in;
                end
            end
            tx_ready_out <= src_next == GDC_SRC_IDLE && src_active
                && !src_take && !tx_ready_out;
            dav_oe_out <= src_next == GDC_SRC_VALID;
            dio_oe_out <= (src_next == GDC_SRC_SETUP
                || src_next == GDC_SRC_VALID) ? ((src_reg == GDC_SRC_IDLE)
                ? (spoll_out ? status_in : tx_data_in) : out_byte_reg)
                : 8'h00;
            eoi_oe_out <= src_next == GDC_SRC_VALID && out_last_reg;
        end
    end

    // ========================================================================
    // Checks
    // ========================================================================
    property p_mla;
        @(posedge clk_in) disable iff (!rst_n_in)
        cmd_stb && !ifc && cmd[6:5] == GDC_GRP_LISTEN && my_addr
            && cmd != GDC_CMD_UNL |=> listen_out && !talk_out;
    endproperty
    a_mla: assert property (p_mla)
        else $error("own listen address did not make a listener");

    property p_mta;
        @(posedge clk_in) disable iff (!rst_n_in)
        cmd_stb && !ifc && cmd[6:5] == GDC_GRP_TALK && my_addr
            && cmd != GDC_CMD_UNT |=> talk_out && !listen_out;
    endproperty
    a_mta: assert property (p_mta)
        else $error("own talk address did not make a talker");

    property p_unl;
        @(posedge clk_in) disable iff (!rst_n_in)
        cmd_stb && cmd == GDC_CMD_UNL |=> !listen_out;
    endproperty
    a_unl: assert property (p_unl)
        else $error("unlisten left the listener active");

    property p_unt;
        @(posedge clk_in) disable iff (!rst_n_in)
        cmd_stb && cmd == GDC_CMD_UNT |=> !talk_out;
    endproperty
    a_unt: assert property (p_unt)
        else $error("untalk left the talker active");

    property p_sec;
        @(posedge clk_in) disable iff (!rst_n_in)
        cmd_stb && !ifc && cmd[6:5] == GDC_GRP_SECOND
            |=> $stable(listen_out) && $stable(talk_out);
    endproperty
    a_sec: assert property (p_sec)
        else $error("secondary byte changed addressing");

    property p_sdc;
        @(posedge clk_in) disable iff (!rst_n_in)
        cmd_stb && cmd == GDC_CMD_SDC |=> clear_out == $past(listen_out);
    endproperty
    a_sdc: assert property (p_sdc)
        else $error("selective clear ignored addressing");

    property p_get;
        @(posedge clk_in) disable iff (!rst_n_in)
        trigger_out |-> $past(cmd_stb && cmd == GDC_CMD_GET && listen_out);
    endproperty
    a_get: assert property (p_get)
        else $error("trigger without an addressed trigger command");

    property p_ifc;
        @(posedge clk_in) disable iff (!rst_n_in)
        ifc |=> !listen_out && !talk_out;
    endproperty
    a_ifc: assert property (p_ifc)
        else $error("interface clear left an addressed state");

    property p_dav_wait;
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(dav_oe_out) |-> $past(nrfd_n_in && !ndac_n_in && talk_out);
    endproperty
    a_dav_wait: assert property (p_dav_wait)
        else $error("data valid asserted before the bus was ready");

    property p_gtl;
        @(posedge clk_in) disable iff (!rst_n_in)
        cmd_stb && cmd == GDC_CMD_GTL && listen_out |=> !remote_out;
    endproperty
    a_gtl: assert property (p_gtl)
        else $error("go to local left remote mode set");
endmodule : gdc_top

// File: verif/gdc_ctl_model.sv
// Bus controller model: sources command and data bytes, accepts talker bytes.
// Assumes the bench resolves every wired line from all output enables.
`timescale 1ns/1ps
module gdc_ctl_model (
    input wire logic clk_in,
    input wire logic [7:0] dio_n_in,
    input wire logic dav_n_in,
    input wire logic nrfd_n_in,
    input wire logic ndac_n_in,
    output logic [7:0] dio_oe_out,
    output logic dav_oe_out,
    output logic nrfd_oe_out,
    output logic ndac_oe_out
);
    // ========================================================================
    // Handshake tasks
    // ========================================================================
    initial begin
        dio_oe_out = 8'h00;
        dav_oe_out = 1'b0;
        nrfd_oe_out = 1'b0;
        ndac_oe_out = 1'b0;
    end

    // Released lines fall back to the pull-up, never to the last byte.
    task automatic send_byte(input logic [7:0] b);
        @(negedge clk_in);
        dio_oe_out = b;
        @(negedge clk_in);
        for (int i = 0; i < 300 && !(nrfd_n_in && !ndac_n_in); i++) begin
            @(negedge clk_in);
        end
        dav_oe_out = 1'b1;
        for (int i = 0; i < 300 && !ndac_n_in; i++) begin
            @(negedge clk_in);
        end
        dav_oe_out = 1'b0;
        dio_oe_out = 8'h00;
    endtask : send_byte

    task automatic recv_byte(output logic [7:0] b);
        @(negedge clk_in);
        ndac_oe_out = 1'b1;
        for (int i = 0; i < 300 && dav_n_in; i++) begin
            @(negedge clk_in);
        end
        b = ~dio_n_in;
        nrfd_oe_out = 1'b1;
        ndac_oe_out = 1'b0;
        for (int i = 0; i < 300 && !dav_n_in; i++) begin
            @(negedge clk_in);
        end
        nrfd_oe_out = 1'b0;
    endtask : recv_byte

endmodule : gdc_ctl_model

// File: verif/gdc_device_command_decoder_tb_top.sv
// Self-checking bench for the command decoder against a controller model.
// Assumes pull-ups on every bus line; enables pull lines low.
`timescale 1ns/1ps
module gdc_device_command_decoder_tb_top;
    import gdc_pkg::*;
    // ========================================================================
    // Bench wiring
    // ========================================================================
    localparam logic [7:0] MLA = 8'h2b;
    localparam logic [7:0] MTA = 8'h4b;
    logic clk_in = 0, rst_n_in = 0, atn_n_in = 1, ifc_n_in = 1, ren_n_in = 1;
    logic srq_req_in = 0, tx_last_in = 0, tx_valid_in = 0, rx_ready_in = 0;
    logic [4:0] prim_addr_in = 5'h0b;
    logic [7:0] status_in = 8'h05, tx_data_in = 8'ha5, dio_oe_out, m_dio, b;
    logic dav_oe_out, nrfd_oe_out, ndac_oe_out, eoi_oe_out, srq_oe_out;
    logic tx_ready_out, rx_valid_out, listen_out, talk_out, remote_out;
    logic lockout_out, spoll_out, clear_out, trigger_out;
    logic m_dav, m_nrfd, m_ndac;
    logic [7:0] rx_data_out;
    wire logic [7:0] dio_n_in = ~(dio_oe_out | m_dio);
    wire logic dav_n_in = ~(dav_oe_out | m_dav);
    wire logic nrfd_n_in = ~(nrfd_oe_out | m_nrfd);
    wire logic ndac_n_in = ~(ndac_oe_out | m_ndac);
    wire logic eoi_n_in = ~eoi_oe_out;
    int fail_count = 0, n_tests = 0, nclr = 0, ntrg = 0, nrdy = 0;
    logic [7:0] pat [4] = '{8'h2a, 8'h3f, 8'h53, 8'h54};

    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (clear_out === 1'b1) nclr++;
        if (trigger_out === 1'b1) ntrg++;
        if (tx_ready_out === 1'b1) nrdy++;
    end

    gdc_top u_gdc_top (.clk_in, .rst_n_in, .prim_addr_in, .dio_n_in,
        .dio_out(), .dio_oe_out, .atn_n_in, .ifc_n_in, .ren_n_in, .dav_n_in,
        .dav_out(), .dav_oe_out, .nrfd_n_in, .nrfd_out(), .nrfd_oe_out,
        .ndac_n_in, .ndac_out(), .ndac_oe_out, .eoi_n_in, .eoi_out(),
        .eoi_oe_out, .srq_out(), .srq_oe_out, .srq_req_in, .status_in,
        .tx_data_in, .tx_last_in, .tx_valid_in, .tx_ready_out, .rx_data_out,
        .rx_valid_out, .rx_ready_in, .listen_out, .talk_out, .remote_out,
        .lockout_out, .spoll_out, .clear_out, .trigger_out);
    gdc_ctl_model u_gdc_ctl_model (.clk_in, .dio_n_in, .dav_n_in, .nrfd_n_in,
        .ndac_n_in, .dio_oe_out(m_dio), .dav_oe_out(m_dav),
        .nrfd_oe_out(m_nrfd), .ndac_oe_out(m_ndac));

    // ========================================================================
    // Shared tasks
    // ========================================================================
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic xfer(input logic atn, input logic [7:0] v);
        @(negedge clk_in);
        atn_n_in = ~atn;
        u_gdc_ctl_model.send_byte(v);
        repeat (3) @(negedge clk_in);
    endtask : xfer

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_addr;
        xfer(1, 8'h2c); chk("other", 0, 8'(listen_out));
        xfer(1, MLA); chk("listen", 1, 8'(listen_out));
        xfer(1, MTA); chk("talk", 1, 8'(talk_out));
        chk("unlisten", 0, 8'(listen_out));
        xfer(1, 8'h6b); chk("second", 1, 8'(talk_out));
        xfer(1, MLA | 8'h80); chk("mla7", 1, 8'(listen_out));
        chk("untalk", 0, 8'(talk_out));
        xfer(1, MTA); xfer(1, 8'h5f); chk("unt", 0, 8'(talk_out));
        xfer(1, MLA); xfer(1, 8'h3f); chk("unl", 0, 8'(listen_out));
    endtask : t_addr

    task automatic t_cmds;
        ren_n_in = 0;
        xfer(1, 8'h04); chk("sdc_unaddr", 0, 8'(nclr));
        xfer(1, MLA); chk("remote", 1, 8'(remote_out));
        xfer(1, 8'h04); chk("sdc", 1, 8'(nclr));
        xfer(1, 8'h08); chk("get", 1, 8'(ntrg));
        xfer(1, 8'h11); chk("llo", 1, 8'(lockout_out));
        xfer(1, 8'h01); chk("gtl", 0, 8'(remote_out));
        chk("llo_held", 1, 8'(lockout_out));
        xfer(1, 8'h3f); xfer(1, 8'h14); chk("dcl", 2, 8'(nclr));
        xfer(1, 8'h18); chk("spe", 1, 8'(spoll_out));
        xfer(1, 8'h19); chk("spd", 0, 8'(spoll_out));
        ren_n_in = 1;
        repeat (3) @(negedge clk_in);
        chk("llo_ren", 0, 8'(lockout_out));
    endtask : t_cmds

    // Four bytes fill the buffer; the acceptor must then hold off the bus.
    task automatic t_rx;
        xfer(1, MLA);
        foreach (pat[i]) xfer(0, pat[i]);
        chk("data_unl", 1, 8'(listen_out));
        chk("full_nrfd", 0, 8'(nrfd_n_in));
        foreach (pat[i]) begin
            chk("rx", pat[i], rx_data_out);
            rx_ready_in = 1;
            @(negedge clk_in);
            rx_ready_in = 0;
            @(negedge clk_in);
        end
        chk("rx_empty", 0, 8'(rx_valid_out));
    endtask : t_rx

    task automatic t_tx;
        xfer(1, 8'h5f);
        tx_valid_in = 1;
        atn_n_in = 1;
        repeat (20) @(negedge clk_in);
        chk("no_talk", 0, 8'(nrdy));
        xfer(1, MTA);
        atn_n_in = 1;
        for (int i = 0; i < 50 && nrdy == 0; i++) @(negedge clk_in);
        tx_valid_in = 0;
        u_gdc_ctl_model.recv_byte(b);
        chk("tx", 8'ha5, b);
        srq_req_in = 1;
        repeat (3) @(negedge clk_in);
        chk("srq", 1, 8'(srq_oe_out));
        xfer(1, 8'h18); xfer(1, MTA);
        atn_n_in = 1;
        u_gdc_ctl_model.recv_byte(b);
        chk("stb", 8'h45, b);
        repeat (3) @(negedge clk_in);
        chk("srq_off", 0, 8'(srq_oe_out));
    endtask : t_tx

    task automatic t_ifc;
        ifc_n_in = 0;
        repeat (3) @(negedge clk_in);
        chk("ifc_talk", 0, 8'(talk_out));
        chk("ifc_spoll", 0, 8'(spoll_out));
        ifc_n_in = 1;
    endtask : t_ifc

    initial begin
        repeat (6) @(negedge clk_in);
        rst_n_in = 1;
        t_addr();
        t_cmds();
        t_rx();
        t_tx();
        t_ifc();
        end_sim();
    end

    // A stuck handshake ends the run long before this span runs out.
    initial begin
        #200000;
        fail_count++;
        end_sim();
    end
endmodule : gdc_device_command_decoder_tb_top
